// ===== logic/spe_pkg.sv
package spe_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_RXD = 8'h10;
  localparam logic [7:0] OFF_TXD = 8'h14;
  localparam logic [7:0] OFF_ERRC = 8'h18;
  // control_reg command bits, write-only, each acts when written as one
  localparam int CTRL_RX_RESET = 0;
  localparam int CTRL_RTS_HIGH = 1;
  localparam int CTRL_RTS_LOW = 2;
  localparam int CTRL_ENABLE = 3;
  localparam int CTRL_DISABLE = 4;
  // status and mask bit positions
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_DONE = 1;
  localparam int ST_OVERLONG = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_W = 4;
  // mode_reg field
  localparam int MODE_W = 3;
  typedef enum logic [2:0] {
    SPE_NORMAL = 3'b000,
    SPE_HANDSHAKE = 3'b001,
    SPE_SC_BLOCK = 3'b010,
    SPE_SPI_SLAVE = 3'b011,
    SPE_SYNC_SLAVE = 3'b100
  } spe_mode_t;
  // reset values
  localparam logic [7:0] TX_IDLE = 8'hFF;
  localparam logic [ST_W-1:0] MASK_RESET = 4'h0;
  localparam logic [7:0] ERRC_RESET = 8'h00;
  localparam logic RTS_RESET = 1'b0;
  // far side keeps the link clock at least this many system clocks per period
  localparam int LINK_MIN_RATIO = 9;
endpackage

// ===== logic/spe_link.sv
`timescale 1ns/1ps
// link shifter: samples the external serial clock, frame select and data
module spe_link
  import spe_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic rxd,
  input wire logic [DW-1:0] tx_byte,
  output logic txd,
  output logic frame_start,
  output logic frame_done,
  output logic [DW-1:0] rx_byte,
  output logic [4:0] bit_count
);
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [1:0] prev;
  logic [DW-1:0] sh_rx, next_sh_rx, sh_tx, next_sh_tx, next_rx_byte;
  logic [4:0] next_bit_count;
  logic next_txd, next_frame_start, next_frame_done;
  logic in_frame, rise, fall, sel_fall, sel_rise;

  // the five-bit counter must still see a frame one bit too long
  if (DW < 2 || DW > 30) begin : g_dw_check
    $error("spe_link: DW out of range");
  end

  // two flip-flops per pin; the first stage feeds only the second
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync1[i] <= 1'b1;
        sync2[i] <= 1'b1;
      end else begin
        sync1[i] <= (i == 0) ? link_clk : (i == 1) ? sel_n : rxd;
        sync2[i] <= sync1[i];
      end
    end
  end

  assign in_frame = !sync2[1];
  assign rise = sync2[0] && !prev[0] && in_frame;
  assign fall = !sync2[0] && prev[0] && in_frame;
  assign sel_fall = prev[1] && !sync2[1];
  assign sel_rise = !prev[1] && sync2[1];

  // shifting: data in on rising link edges, out on falling, msb first
  always_comb begin
    next_sh_rx = sh_rx;
    next_sh_tx = sh_tx;
    next_txd = txd;
    next_bit_count = bit_count;
    next_rx_byte = rx_byte;
    next_frame_start = sel_fall;
    next_frame_done = sel_rise;
    if (sel_fall) begin
      next_sh_tx = tx_byte;
      next_txd = tx_byte[DW-1];
      next_bit_count = 5'h00;
    end else begin
      if (rise) begin
        next_sh_rx = {sh_rx[DW-2:0], sync2[2]};
        // saturate so an over-long frame still reads as too long
        if (bit_count != 5'h1F) next_bit_count = bit_count + 5'h01;
      end
      if (fall) begin
        next_sh_tx = {sh_tx[DW-2:0], 1'b1};
        next_txd = sh_tx[DW-2];
      end
    end
    if (sel_rise) begin
      next_rx_byte = sh_rx;
      next_txd = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 2'h3;
      sh_rx <= '0;
      sh_tx <= '1;
      txd <= 1'b1;
      bit_count <= 5'h00;
      rx_byte <= '0;
      frame_start <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      prev <= sync2[1:0];
      sh_rx <= next_sh_rx;
      sh_tx <= next_sh_tx;
      txd <= next_txd;
      bit_count <= next_bit_count;
      rx_byte <= next_rx_byte;
      frame_start <= next_frame_start;
      frame_done <= next_frame_done;
    end
  end
endmodule

// ===== logic/spe_port.sv
`timescale 1ns/1ps
// Contract
// - smartcard mode: error count reads zero
// - smartcard block: receive locked after transmit
// - handshake mode: rts never raised automatically
// - force-high command drives rts high
// - force-low command drives rts low; if force-high is written with it, rts goes high
// - over-long spi frame errors, corrupts next reception
module spe_port
  import spe_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic sel_n,
  input wire logic rxd,
  output logic txd,
  output logic rts,
  output logic irq
);
  spe_mode_t mode, next_mode;
  logic [ST_W-1:0] status, next_status, mask, next_mask;
  logic [DW-1:0] rx_data, next_rx_data, tx_data, next_tx_data;
  logic [7:0] err_count, next_err_count;
  logic enabled, next_enabled, rx_lock, next_rx_lock, corrupt, next_corrupt;
  logic tx_pending, next_tx_pending, tx_loaded, next_tx_loaded;
  logic next_rts, next_irq, next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic acc, wr, rd, ctrl_wr, mapped, accept;
  logic link_start, link_done;
  logic [DW-1:0] link_byte, link_tx;
  logic [4:0] link_bits;

  // the idle pattern and the register layout hold at most eight data bits
  if (DW < 2 || DW > 8) begin : g_dw_check
    $error("spe_port: DW out of range");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // one wait state: pready rises in the second access cycle
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign ctrl_wr = wr && hit(paddr, OFF_CTRL);
  assign mapped = hit(paddr, OFF_CTRL) || hit(paddr, OFF_MODE) || hit(paddr, OFF_STAT)
    || hit(paddr, OFF_MASK) || hit(paddr, OFF_RXD) || hit(paddr, OFF_TXD)
    || hit(paddr, OFF_ERRC);
  assign link_tx = tx_pending ? tx_data : TX_IDLE[DW-1:0];

  spe_link #(.DW(DW)) spe_link_i (
    .clk(clk),
    .arst_n(arst_n),
    .link_clk(link_clk),
    .sel_n(sel_n),
    .rxd(rxd),
    .tx_byte(link_tx),
    .txd(txd),
    .frame_start(link_start),
    .frame_done(link_done),
    .rx_byte(link_byte),
    .bit_count(link_bits)
  );

  // a full frame is taken while enabled unless the smartcard block lock holds it off
  assign accept = link_done && enabled && link_bits == 5'(DW)
    && !(mode == SPE_SC_BLOCK && rx_lock);

  // apb answer path
  always_comb begin
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !mapped;
    next_prdata = prdata;
    if (psel && penable && !pready) begin
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit(paddr, OFF_MODE): next_prdata = {29'h0, mode};
          hit(paddr, OFF_STAT): next_prdata = {28'h0, status};
          hit(paddr, OFF_MASK): next_prdata = {28'h0, mask};
          hit(paddr, OFF_RXD): next_prdata = 32'(rx_data);
          hit(paddr, OFF_TXD): next_prdata = 32'(tx_data);
          // count is kept but never visible while in smartcard mode
          hit(paddr, OFF_ERRC):
            next_prdata = (mode == SPE_SC_BLOCK) ? 32'h0 : {24'h0, err_count};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // control, link and interrupt state
  always_comb begin
    next_mode = mode;
    next_mask = mask;
    next_tx_data = tx_data;
    next_rx_data = rx_data;
    next_status = status;
    next_err_count = err_count;
    next_enabled = enabled;
    next_rx_lock = rx_lock;
    next_corrupt = corrupt;
    next_tx_pending = tx_pending;
    next_tx_loaded = tx_loaded;
    next_rts = rts;
    // clears first so that hardware events below win in the same cycle
    if (wr && hit(paddr, OFF_STAT)) next_status = status & ~pwdata[ST_W-1:0];
    if (rd && hit(paddr, OFF_RXD)) next_status[ST_RX_READY] = 1'b0;
    if (wr && hit(paddr, OFF_MODE)) next_mode = spe_mode_t'(pwdata[MODE_W-1:0]);
    if (wr && hit(paddr, OFF_MASK)) next_mask = pwdata[ST_W-1:0];
    if (wr && hit(paddr, OFF_TXD)) begin
      next_tx_data = pwdata[DW-1:0];
      next_tx_pending = 1'b1;
    end
    if (ctrl_wr) begin
      if (pwdata[CTRL_RX_RESET]) begin
        // the only way out of the block-mode lock; corruption hazard survives
        next_rx_lock = 1'b0;
        next_status[ST_RX_READY] = 1'b0;
      end
      if (pwdata[CTRL_ENABLE]) next_enabled = 1'b1;
      if (pwdata[CTRL_DISABLE]) next_enabled = 1'b0;
      // rts only ever moves on these commands, in every mode; high wins a tie
      if (pwdata[CTRL_RTS_LOW]) next_rts = 1'b0;
      if (pwdata[CTRL_RTS_HIGH]) next_rts = 1'b1;
    end
    if (link_start && enabled) begin
      next_tx_loaded = tx_pending;
      next_tx_pending = 1'b0;
    end
    if (link_done) begin
      next_tx_loaded = 1'b0;
      if (tx_loaded) begin
        next_status[ST_TX_DONE] = 1'b1;
        if (mode == SPE_SC_BLOCK) next_rx_lock = 1'b1;
      end
      if (enabled && mode == SPE_SPI_SLAVE && link_bits > 5'(DW)) begin
        next_status[ST_OVERLONG] = 1'b1;
        next_corrupt = 1'b1;
      end
    end
    if (accept) begin
      // the reception after an over-long frame comes out damaged
      next_rx_data = corrupt ? ~link_byte : link_byte;
      next_corrupt = 1'b0;
      if (status[ST_RX_READY]) begin
        next_status[ST_OVERRUN] = 1'b1;
        if (err_count != 8'hFF) next_err_count = err_count + 8'h01;
      end
      next_status[ST_RX_READY] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= SPE_NORMAL;
      mask <= MASK_RESET;
      status <= '0;
      tx_data <= TX_IDLE[DW-1:0];
      rx_data <= '0;
      err_count <= ERRC_RESET;
      enabled <= 1'b0;
      rx_lock <= 1'b0;
      corrupt <= 1'b0;
      tx_pending <= 1'b0;
      tx_loaded <= 1'b0;
      rts <= RTS_RESET;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      mode <= next_mode;
      mask <= next_mask;
      status <= next_status;
      tx_data <= next_tx_data;
      rx_data <= next_rx_data;
      err_count <= next_err_count;
      enabled <= next_enabled;
      rx_lock <= next_rx_lock;
      corrupt <= next_corrupt;
      tx_pending <= next_tx_pending;
      tx_loaded <= next_tx_loaded;
      rts <= next_rts;
      irq <= next_irq;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  err_read_zero_a: assert property (
    (psel && penable && !pready && !pwrite && hit(paddr, OFF_ERRC) && mode == SPE_SC_BLOCK)
    |=> pready && prdata == 32'h0)
    else $error("error count visible in smartcard mode");
  rx_locked_a: assert property (
    (link_done && rx_lock && mode == SPE_SC_BLOCK) |=> $stable(rx_data))
    else $error("reception while block lock held");
  lock_after_tx_a: assert property (
    (link_done && tx_loaded && mode == SPE_SC_BLOCK) |=> rx_lock)
    else $error("no lock after smartcard transmit");
  rts_no_auto_a: assert property (
    (!ctrl_wr && mode == SPE_HANDSHAKE) |=> $stable(rts))
    else $error("rts moved without a command");
  rts_high_a: assert property (
    (ctrl_wr && pwdata[CTRL_RTS_HIGH]) |=> rts ##1 rts || ctrl_wr)
    else $error("rts not driven high");
  rts_low_a: assert property (
    (ctrl_wr && pwdata[CTRL_RTS_LOW] && !pwdata[CTRL_RTS_HIGH]) |=> !rts)
    else $error("rts not driven low");
  overlong_err_a: assert property (
    (link_done && enabled && mode == SPE_SPI_SLAVE && link_bits > 5'(DW))
    |=> corrupt && status[ST_OVERLONG])
    else $error("over-long frame not flagged");
  corrupt_next_a: assert property (
    (accept && corrupt) |=> rx_data == ~$past(link_byte) && !corrupt)
    else $error("reception after over-long frame not damaged");
  irq_level_a: assert property (
    irq == |(status & mask))
    else $error("interrupt level wrong");

  lock_cycle_c: cover property (rx_lock ##[1:200] (ctrl_wr && pwdata[CTRL_RX_RESET]));
  rts_pause_c: cover property ($rose(rts) ##[1:200] $fell(rts));
  overlong_c: cover property ($rose(corrupt) ##[1:1000] accept);
  irq_c: cover property ($rose(irq));
endmodule

// ===== bench/spe_far_model.sv
`timescale 1ns/1ps
// far-side serial device; its link clock idles low and only runs inside frames
module spe_far_model (
  input wire logic clk,
  input wire logic txd,
  output logic link_clk,
  output logic sel_n,
  output logic rxd
);
  initial begin
    link_clk = 1'b0;
    sel_n = 1'b1;
    rxd = 1'b0;
  end
  // msb first; data moves on the fall, txd is taken just before the fall
  // the link period is nine system clocks, the lowest ratio the port tolerates
  localparam int HALF_NS = spe_pkg::LINK_MIN_RATIO * 5;
  task automatic frame(input int nb, input logic [15:0] d, input int gap,
                       output logic [7:0] got);
    got = 8'h00;
    repeat (gap) @(posedge clk);
    #2 sel_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      rxd = d[i];
      #(HALF_NS) link_clk = 1'b1;
      #(HALF_NS - 2) got = {got[6:0], txd};
      #2 link_clk = 1'b0;
    end
    #(HALF_NS) sel_n = 1'b1;
    rxd = ~rxd; // released line must not keep the last bit
  endtask
endmodule

// ===== bench/test_spe_port.sv
`timescale 1ns/1ps
module test_spe_port;
  import spe_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, txd, rts, irq, link_clk, sel_n, rxd, err;
  logic [7:0] got;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  spe_port #(.DW(8)) spe_port_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .sel_n(sel_n), .rxd(rxd), .txd(txd), .rts(rts), .irq(irq));
  spe_far_model spe_far_model_i (.clk(clk), .txd(txd), .link_clk(link_clk),
    .sel_n(sel_n), .rxd(rxd));
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) check("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk); // lets registered pins settle
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rx(input int nb, input logic [15:0] d);
    spe_far_model_i.frame(nb, d, 4, got);
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    check("rts", {31'h0, rts}, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b0, OFF_MASK, 32'h0);
    check("mask", rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    wr(OFF_CTRL, 32'h1 << CTRL_ENABLE);
  endtask
  task automatic t_rts();
    wr(OFF_MODE, 32'h0);
    wr(OFF_CTRL, 32'h1 << CTRL_RTS_HIGH);
    check("rts", {31'h0, rts}, 32'h1);
    wr(OFF_CTRL, 32'h1 << CTRL_RTS_LOW);
    check("rts", {31'h0, rts}, 32'h0);
    wr(OFF_CTRL, 32'h6);
    check("rts", {31'h0, rts}, 32'h1);
    wr(OFF_CTRL, 32'h4);
  endtask
  task automatic t_hs();
    wr(OFF_MODE, 32'h1);
    wr(OFF_MASK, 32'h1);
    rx(8, 16'h3C);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, OFF_RXD, 32'h0);
    check("rx data", rd, 32'h3C);
    check("irq", {31'h0, irq}, 32'h0);
    rx(8, 16'h01);
    rx(8, 16'h02);
    check("rts", {31'h0, rts}, 32'h0);
    apb(1'b0, OFF_ERRC, 32'h0);
    check("errcount", rd, 32'h1);
    wr(OFF_MODE, 32'h2);
    apb(1'b0, OFF_ERRC, 32'h0);
    check("errcount", rd, 32'h0);
    apb(1'b0, OFF_RXD, 32'h0);
    wr(OFF_STAT, 32'hF);
  endtask
  task automatic t_block();
    wr(OFF_TXD, 32'h96);
    rx(8, 16'h11);
    check("tx byte", {24'h0, got}, 32'h96);
    apb(1'b0, OFF_STAT, 32'h0);
    check("tx done", rd & 32'h3, 32'h3);
    apb(1'b0, OFF_RXD, 32'h0);
    check("rx data", rd, 32'h11);
    wr(OFF_STAT, 32'hF);
    rx(8, 16'h22);
    apb(1'b0, OFF_STAT, 32'h0);
    check("rx lock", rd & 32'h1, 32'h0);
    // soft reset of the receiver, then mode and control again
    wr(OFF_CTRL, 32'h1 << CTRL_RX_RESET);
    wr(OFF_MODE, 32'h2);
    wr(OFF_CTRL, 32'h1 << CTRL_ENABLE);
    rx(8, 16'h33);
    check("tx idle", {24'h0, got}, {24'h0, TX_IDLE});
    apb(1'b0, OFF_RXD, 32'h0);
    check("rx data", rd, 32'h33);
  endtask
  task automatic t_spi();
    wr(OFF_MODE, 32'h3);
    wr(OFF_STAT, 32'hF);
    rx(9, 16'h155);
    apb(1'b0, OFF_STAT, 32'h0);
    check("overlong", (rd >> ST_OVERLONG) & 32'h1, 32'h1);
    wr(OFF_CTRL, 32'h1 << CTRL_DISABLE);
    wr(OFF_CTRL, 32'h1 << CTRL_RX_RESET);
    wr(OFF_CTRL, 32'h1 << CTRL_ENABLE);
    rx(8, 16'h5A);
    apb(1'b0, OFF_RXD, 32'h0);
    check("rx data", rd, 32'hA5);
    rx(8, 16'h5A);
    apb(1'b0, OFF_RXD, 32'h0);
    check("rx data", rd, 32'h5A);
  endtask
  // hang guard; the whole run needs about a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_rts();
    t_hs();
    t_block();
    t_spi();
    finish_test();
  end
endmodule
